// file: rtl/itx_pkg.sv
// package for the isochronous transmit header control block
package itx_pkg;

  // register map
  localparam logic [7:0]  ITX_CTRL_OFFS = 8'h34;
  localparam logic [31:0] ITX_CTRL_RST  = 32'h0000_0000;

  // control field positions
  localparam int TAG_LSB   = 14;
  localparam int CHAN_LSB  = 8;
  localparam int SPEED_LSB = 4;
  localparam int SYNC_LSB  = 0;
  localparam int SYNC_KEY_BIT = 1;

  // speed codes
  localparam logic [1:0] SPD_100 = 2'h0;
  localparam logic [1:0] SPD_200 = 2'h1;
  localparam logic [1:0] SPD_400 = 2'h2;
  localparam logic [1:0] SPD_RSV = 2'h3;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // header fields handed to the packet builder
  typedef struct packed {
    logic [1:0] tag;
    logic [5:0] chan;
    logic [1:0] speed;
    logic [3:0] sync;
  } itx_hdr_t;

  // av port byte with its key state
  typedef struct packed {
    logic       sop;
    logic       key;
    logic [7:0] data;
  } itx_byte_t;

endpackage

// file: rtl/itx_hdr_ctrl.sv
// isochronous transmit header control with axi4-lite control register
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - the programmed two-bit tag goes into every sent packet header.
// - the programmed six-bit channel goes into every sent packet header.
// - the two-bit speed field selects 100, 200 or 400 Mb/s; 11 is reserved.
// - the four-bit sync field is read-only and goes into every header.
// - sync bit 1 is the packet key parity, 0 even and 1 odd, from the pin.
// - the key pin is sampled at the av clock edge taking a packet's 1st byte.
// - each packet's key state travels with it through the fifo to the bus.
// - on receive the output key stays constant for all bytes of a packet.
module itx_hdr_ctrl
  import itx_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // transmit av port
  input  wire logic        av_port_clock_i,
  input  wire logic        av_tx_sop_i,
  input  wire logic        av_tx_valid_i,
  input  wire logic [7:0]  av_tx_data_i,
  input  wire logic        key_parity_pin_i,
  // byte stream toward the transmit fifo, key tagged
  output logic             tx_byte_valid_o,
  output itx_byte_t        tx_byte_o,
  output itx_hdr_t         tx_hdr_o,
  // receive side: bytes out of the receive fifo
  input  wire logic        rx_byte_valid_i,
  input  wire logic        rx_sop_i,
  input  wire logic        rx_key_i,
  output logic             rx_key_parity_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [2:0]  clk_sync;
    logic [1:0]  sop_sync;
    logic [1:0]  val_sync;
    logic [1:0]  key_sync;
    logic [15:0] dat_sync;
    logic        pkt_key;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  tag;
    logic [5:0]  chan;
    logic [1:0]  speed;
    logic        tx_valid;
    itx_byte_t   tx_byte;
    itx_hdr_t    hdr;
    logic        rx_key;
  } itx_state_t;

  itx_state_t st_reg;
  itx_state_t st_next;
  logic       rst_n;

  assign rst_n = st_reg.rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] ctrl_word(input logic [1:0] tag,
                                            input logic [5:0] chan,
                                            input logic [1:0] spd,
                                            input logic [3:0] sync);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TAG_LSB +: 2]   = tag;
    w[CHAN_LSB +: 6]  = chan;
    w[SPEED_LSB +: 2] = spd;
    w[SYNC_LSB +: 4]  = sync;
    return w;
  endfunction

  function automatic logic is_ctrl(input logic [7:0] addr);
    return addr[7:2] == ITX_CTRL_OFFS[7:2];
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [31:0] cur;
    logic [31:0] wr;
    logic        av_rise;
    st_next = st_reg;
    cur = 32'h0000_0000;
    wr = 32'h0000_0000;
    av_rise = 1'b0;

    st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};

    // av port inputs through two flops before use
    st_next.clk_sync = {st_reg.clk_sync[1:0], av_port_clock_i};
    st_next.sop_sync = {st_reg.sop_sync[0], av_tx_sop_i};
    st_next.val_sync = {st_reg.val_sync[0], av_tx_valid_i};
    st_next.key_sync = {st_reg.key_sync[0], key_parity_pin_i};
    st_next.dat_sync = {st_reg.dat_sync[7:0], av_tx_data_i};
    av_rise = st_reg.clk_sync[1] & ~st_reg.clk_sync[2];

    cur = ctrl_word(st_reg.tag, st_reg.chan, st_reg.speed, st_reg.hdr.sync);

    // av byte capture on each av clock rising edge
    st_next.tx_valid = 1'b0;
    if (av_rise && st_reg.val_sync[1])
    begin
      if (st_reg.sop_sync[1])
      begin
        st_next.pkt_key = st_reg.key_sync[1];
      end
      st_next.tx_valid = 1'b1;
      st_next.tx_byte.sop = st_reg.sop_sync[1];
      st_next.tx_byte.key = st_reg.sop_sync[1] ? st_reg.key_sync[1]
                                               : st_reg.pkt_key;
      st_next.tx_byte.data = st_reg.dat_sync[15:8];
    end

    // header fields presented with every packet
    st_next.hdr.tag = st_reg.tag;
    st_next.hdr.chan = st_reg.chan;
    st_next.hdr.speed = st_reg.speed;
    st_next.hdr.sync = 4'h0;
    st_next.hdr.sync[SYNC_KEY_BIT] = st_next.pkt_key;

    // receive key held for a whole packet
    if (rx_byte_valid_i && rx_sop_i)
    begin
      st_next.rx_key = rx_key_i;
    end

    // axi write channels
    if (s_axi_awvalid_i && st_reg.awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
      st_next.awready = 1'b0;
    end

    if (s_axi_wvalid_i && st_reg.wready)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata_i;
      st_next.w_strb = s_axi_wstrb_i;
      st_next.wready = 1'b0;
    end

    // both halves in: apply and answer
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      if (is_ctrl(st_reg.aw_addr))
      begin
        st_next.bresp = RESP_OKAY;
        wr = strb_merge(cur, st_reg.w_data, st_reg.w_strb);
        st_next.tag = wr[TAG_LSB +: 2];
        st_next.chan = wr[CHAN_LSB +: 6];
        if (wr[SPEED_LSB +: 2] != SPD_RSV)
        begin
          st_next.speed = wr[SPEED_LSB +: 2];
        end
        // sync and unassigned bits ignore writes
      end
      else
      begin
        st_next.bresp = RESP_SLVERR;
      end
    end

    // response taken: reopen the write channels
    if (st_reg.bvalid && s_axi_bready_i)
    begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // write channels open once nothing is pending
    if (!st_reg.bvalid && !st_reg.aw_got && !st_reg.w_got
        && !st_reg.awready && !st_reg.wready)
    begin
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // axi read channel
    if (s_axi_arvalid_i && st_reg.arready)
    begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      if (is_ctrl(s_axi_araddr_i))
      begin
        st_next.rdata = cur;
        st_next.rresp = RESP_OKAY;
      end
      else
      begin
        st_next.rdata = 32'h0000_0000;
        st_next.rresp = RESP_SLVERR;
      end
    end

    // read answered: reopen the address channel
    if (st_reg.rvalid && s_axi_rready_i)
    begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // read channel opens once nothing is pending
    if (!st_reg.rvalid && !st_reg.arready)
    begin
      st_next.arready = 1'b1;
    end

    // everything but the reset synchroniser held until release
    if (!rst_n)
    begin
      st_next = '0;
      st_next.rst_sync = {st_reg.rst_sync[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready_o = st_reg.awready;
  assign s_axi_wready_o  = st_reg.wready;
  assign s_axi_bvalid_o  = st_reg.bvalid;
  assign s_axi_bresp_o   = st_reg.bresp;
  assign s_axi_arready_o = st_reg.arready;
  assign s_axi_rvalid_o  = st_reg.rvalid;
  assign s_axi_rdata_o   = st_reg.rdata;
  assign s_axi_rresp_o   = st_reg.rresp;
  assign tx_byte_valid_o = st_reg.tx_valid;
  assign tx_byte_o       = st_reg.tx_byte;
  assign tx_hdr_o        = st_reg.hdr;
  assign rx_key_parity_o = st_reg.rx_key;

endmodule

// file: testbench/itx_checker.sv
// assertions for the transmit header control block
`timescale 1ns/1ps
module itx_checker
  import itx_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        tx_byte_valid_o,
  input wire itx_byte_t   tx_byte_o,
  input wire itx_hdr_t    tx_hdr_o,
  input wire logic        rx_byte_valid_i,
  input wire logic        rx_sop_i,
  input wire logic        rx_key_i,
  input wire logic        rx_key_parity_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  chk_rx_key_load: assert property (rx_byte_valid_i && rx_sop_i |=>
    rx_key_parity_o == $past(rx_key_i)) else $error("rx key not taken");
  chk_rx_key_hold: assert property (!(rx_byte_valid_i && rx_sop_i) |=>
    $stable(rx_key_parity_o)) else $error("rx key moved mid packet");
  chk_sync_fixed: assert property (tx_hdr_o.sync[3:2] == 2'h0 &&
    !tx_hdr_o.sync[0]) else $error("sync spare bits set");
  chk_speed_legal: assert property (tx_hdr_o.speed != SPD_RSV)
    else $error("reserved speed used");
  chk_key_follow: assert property (tx_byte_valid_o && !tx_byte_o.sop |->
    tx_byte_o.key == $past(tx_byte_o.key)) else $error("key changed");
  chk_key_hdr: assert property (tx_byte_valid_o && tx_byte_o.sop |->
    ##[0:4] tx_hdr_o.sync[1] == tx_byte_o.key) else $error("sync key");
  chk_rd_unused: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:16] == 16'h0 && s_axi_rdata_o[7:6] == 2'h0)
    else $error("unused bits read set");
  chk_byte_pulse: assert property (tx_byte_valid_o |=> !tx_byte_valid_o)
    else $error("byte strobe too long");
  cover property (tx_byte_valid_o && tx_byte_o.key);
  cover property (rx_byte_valid_i && rx_sop_i && rx_key_i);
  cover property (s_axi_rvalid_o && s_axi_rdata_o[1]);
endmodule
bind itx_hdr_ctrl itx_checker u_chk (.clk_sys_i, .nrst_i, .s_axi_rvalid_o,
  .s_axi_rdata_o, .tx_byte_valid_o, .tx_byte_o, .tx_hdr_o,
  .rx_byte_valid_i, .rx_sop_i, .rx_key_i, .rx_key_parity_o);

// file: testbench/itx_codec_model.sv
// codec model driving the transmit av port
`timescale 1ns/1ps
module itx_codec_model (
  input  wire logic clk_i,
  output logic      av_clk_o = 1'b0,
  output logic      sop_o = 1'b0,
  output logic      valid_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic      key_o = 1'b0
);
  // one packet; the pin flips after the first byte, which must not matter
  task automatic send(input logic k, input logic [7:0] d0, input int n);
    @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      sop_o <= (i == 0);
      valid_o <= 1'b1;
      data_o <= d0 + 8'(i);
      key_o <= (i == 0) ? k : ~k;
      repeat (4) @(posedge clk_i);
      av_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      av_clk_o <= 1'b0;
    end
    valid_o <= 1'b0;
    sop_o <= 1'b0;
    data_o <= ~data_o;
  endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the transmit header control block
`timescale 1ns/1ps
module testbench;
  import itx_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        rxv = 1'b0, rxs = 1'b0, rxk = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d32;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        av_port_clock, sop, valid, key, tbv, rkey;
  logic [7:0]  data;
  itx_byte_t   tb;
  itx_hdr_t    hdr;
  itx_byte_t   q[$];
  int          n_mismatch = 0, n_checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  itx_hdr_ctrl dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .av_port_clock_i(av_port_clock), .av_tx_sop_i(sop), .av_tx_valid_i(valid),
    .av_tx_data_i(data), .key_parity_pin_i(key), .tx_byte_valid_o(tbv),
    .tx_byte_o(tb), .tx_hdr_o(hdr), .rx_byte_valid_i(rxv), .rx_sop_i(rxs),
    .rx_key_i(rxk), .rx_key_parity_o(rkey));
  itx_codec_model codec (.clk_i(clk_sys_i), .av_clk_o(av_port_clock), .sop_o(sop),
    .valid_o(valid), .data_o(data), .key_o(key));
  always @(posedge clk_sys_i)
    if (tbv === 1'b1)
      q.push_back(tb);
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok)
    begin
      @(posedge clk_sys_i);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1)
      begin
        b_ok = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (rvalid !== 1'b1);
    d32 = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic t_fields();
    rd(ITX_CTRL_OFFS);
    chk(d32, ITX_CTRL_RST);
    wr(ITX_CTRL_OFFS, 32'hffff_ffff);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(ITX_CTRL_OFFS);
    chk(d32, 32'h0000_ff00);
    for (int s = 0; s < 3; s++)
    begin
      wr(ITX_CTRL_OFFS, 32'h5500 | 32'(s << 4));
      rd(ITX_CTRL_OFFS);
      chk(d32, 32'h5500 | 32'(s << 4));
      chk({18'h0, hdr}, {18'h0, 2'h1, 6'h15, 2'(s), 4'h0});
    end
    wr(ITX_CTRL_OFFS, 32'h5530);
    rd(ITX_CTRL_OFFS);
    chk(d32, 32'h5520);
    rd(8'h38);
    chk(d32, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h30, 32'hffff_ffff);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    $display("done fields");
  endtask
  task automatic t_key(input logic k);
    q.delete();
    codec.send(k, 8'h40, 3);
    repeat (12) @(posedge clk_sys_i);
    chk(32'(q.size()), 32'h3);
    for (int i = 0; i < 3; i++)
      chk({22'h0, q[i]}, {22'h0, i == 0, k, 8'h40 + 8'(i)});
    rd(ITX_CTRL_OFFS);
    chk({28'h0, d32[3:0]}, {30'h0, k, 1'b0});
    chk({28'h0, hdr.sync}, {30'h0, k, 1'b0});
    $display("done key");
  endtask
  task automatic t_rx();
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys_i);
      rxv <= 1'b1;
      rxs <= (i % 3 == 0);
      rxk <= (i < 3) ^ (i % 3 != 0);
      @(posedge clk_sys_i);
      rxv <= 1'b0;
      rxk <= ~rxk;
      @(posedge clk_sys_i);
      chk({31'h0, rkey}, {31'h0, i < 3});
    end
    $display("done rx");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_fields();
    t_key(1'b1);
    t_key(1'b0);
    t_rx();
    wrap_up();
  end
  initial
  begin
    #100us;
    n_mismatch++;
    wrap_up();
  end
endmodule
